// ### cks_clock_ctrl.sv
// Clock source decode, start-up sequencing and trim register with AXI4-Lite access
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "cks_defines.svh"
module cks_clock_ctrl import cks_pkg::*; #(
    parameter int WD_SHORT_CYCLES = 4096,
    parameter int WD_LONG_CYCLES = 65536
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] clockSourceSelect,
    input wire logic [1:0] startupDelaySelect,
    input wire logic configProgrammed,
    input wire logic [7:0] factoryTrim,
    input wire logic watchdogOscTick,
    input wire logic sourceClockTick,
    input wire logic wakeRequest,
    input wire logic sleepRequest,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic coreClockEnable,
    output logic [1:0] activeSource,
    output logic [2:0] frequencyBand,
    output logic [7:0] oscillatorTrimValue,
    output logic nvmTimingFromIntRc,
    output logic nvmTrimUnsafe,
    output logic configInvalid
);
    // The delay counter is 17 bits wide, so longer time-outs cannot be timed
    if (WD_SHORT_CYCLES < 1 || WD_LONG_CYCLES < WD_SHORT_CYCLES ||
        WD_LONG_CYCLES > `CKS_WD_LONG) begin
        $error("watchdog cycle counts out of range");
    end

    // Pins and foreign-clock ticks pass two flops first
    logic [3:0] pinSync;
    cks_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .async({watchdogOscTick, sourceClockTick, wakeRequest, sleepRequest}),
        .synced(pinSync)
    );
    logic wdTickLvl, srcTickLvl, wakeLvl, sleepLvl;
    assign {wdTickLvl, srcTickLvl, wakeLvl, sleepLvl} = pinSync;

    logic wdTickPrev_q, srcTickPrev_q, wakePrev_q, sleepPrev_q;
    wire wdEdge = wdTickLvl & ~wdTickPrev_q;
    wire srcEdge = srcTickLvl & ~srcTickPrev_q;
    wire wakeEdge = wakeLvl & ~wakePrev_q;
    wire sleepEdge = sleepLvl & ~sleepPrev_q;

    // Configuration is caught once after reset release, never under the reset itself
    logic cfgCaught_q;
    logic [3:0] selCfg_q;
    logic [1:0] sutCfg_q;
    wire [3:0] selLive = configProgrammed ? clockSourceSelect : `CKS_SEL_DEFAULT; // R13
    wire [1:0] sutLive = configProgrammed ? startupDelaySelect : `CKS_SUT_DEFAULT; // R13

    function automatic cks_src_t decodeSource(input logic [3:0] sel, input logic [1:0] startup_delay_select);
        cks_src_t src;
        src = CKS_SRC_INVALID;
        if (sel == `CKS_SEL_EXTCLK && startup_delay_select != 2'b11) begin
            src = CKS_SRC_EXTCLK; // R10 R11
        end else if (sel >= `CKS_SEL_INT_LO && sel <= `CKS_SEL_INT_HI && startup_delay_select != 2'b11) begin
            src = CKS_SRC_INTRC; // R3 R4
        end else if (sel >= `CKS_SEL_ERC_LO && sel <= `CKS_SEL_ERC_HI) begin
            src = CKS_SRC_EXTRC; // R1
        end
        return src; // R15
    endfunction

    wire cks_src_t srcDec = decodeSource(selCfg_q, sutCfg_q);
    wire [2:0] bandDec = (srcDec == CKS_SRC_INTRC) ? 3'(selCfg_q - `CKS_SEL_INT_LO) :
                         (srcDec == CKS_SRC_EXTRC) ? 3'(selCfg_q - `CKS_SEL_ERC_LO) : 3'd0;

    // Wake cycle count in source clocks
    wire [4:0] wakeCount = (srcDec == CKS_SRC_EXTRC && sutCfg_q != 2'b11) ?
                           `CKS_WAKE_ERC : `CKS_WAKE_SHORT; // R2 R4 R11

    // Reset delay in watchdog cycles, zero when none
    logic [16:0] resetDelay;
    always_comb begin
        resetDelay = 17'd0;
        if (srcDec == CKS_SRC_EXTRC) begin
            case (sutCfg_q)
                2'b01: resetDelay = 17'(WD_SHORT_CYCLES); // R2 R14
                2'b10: resetDelay = 17'(WD_LONG_CYCLES); // R2 R14
                2'b11: resetDelay = 17'(WD_SHORT_CYCLES); // R2
                default: resetDelay = 17'd0;
            endcase
        end else begin
            case (sutCfg_q)
                2'b01: resetDelay = 17'(WD_SHORT_CYCLES); // R4 R11 R14
                2'b10: resetDelay = 17'(WD_LONG_CYCLES); // R4 R11 R14
                default: resetDelay = 17'd0;
            endcase
        end
    end

    // Start-up sequencer
    cks_state_t state_q, state_d;
    logic [16:0] count_q, count_d;
    logic swSleep_q;

    always_comb begin
        state_d = state_q;
        count_d = count_q;
        case (state_q)
            CKS_ST_RESET: begin
                if (cfgCaught_q) begin
                    count_d = 17'd0;
                    state_d = CKS_ST_TIMEOUT;
                end
            end
            CKS_ST_TIMEOUT: begin
                if (srcDec == CKS_SRC_INVALID) begin
                    state_d = CKS_ST_HALT; // R15
                end else if (count_q >= resetDelay) begin
                    count_d = 17'd0;
                    state_d = CKS_ST_WAKE;
                end else if (wdEdge) begin
                    count_d = count_q + 17'd1; // R6
                end
            end
            CKS_ST_WAKE: begin
                if (count_q >= 17'(wakeCount)) begin
                    state_d = CKS_ST_RUN; // R15
                end else if (srcEdge) begin
                    count_d = count_q + 17'd1;
                end
            end
            CKS_ST_RUN: begin
                if (sleepEdge || swSleep_q) begin
                    state_d = CKS_ST_SLEEP;
                end
            end
            CKS_ST_SLEEP: begin
                if (wakeEdge) begin
                    count_d = 17'd0;
                    state_d = CKS_ST_WAKE;
                end
            end
            default: state_d = CKS_ST_HALT;
        endcase
    end

    // AXI4-Lite slave, single outstanding write and read
    logic awHeld_q, wHeld_q;
    logic [11:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic [7:0] trim_q;
    logic badWrite_q;

    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire awTake = s_axi_awvalid && s_axi_awready;
    wire wTake = s_axi_wvalid && s_axi_wready;
    wire haveAw = awHeld_q || awTake;
    wire haveW = wHeld_q || wTake;
    wire [11:0] wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
    wire [31:0] wrData = wHeld_q ? wData_q : s_axi_wdata;
    wire [3:0] wrStrb = wHeld_q ? wStrb_q : s_axi_wstrb;
    wire doWrite = haveAw && haveW && !s_axi_bvalid;
    wire wrTrim = doWrite && wrAddr == `CKS_ADDR_TRIM;
    wire wrCtrl = doWrite && wrAddr == `CKS_ADDR_CTRL;
    wire wrMapped = wrTrim || wrCtrl;
    wire rdTake = s_axi_arvalid && s_axi_arready;

    logic [31:0] rdValue;
    logic rdOk;
    always_comb begin
        rdValue = 32'h0000_0000;
        rdOk = 1'b1;
        if (s_axi_araddr == `CKS_ADDR_TRIM) begin
            rdValue = {24'h00_0000, trim_q};
        end else if (s_axi_araddr == `CKS_ADDR_CTRL) begin
            rdValue = {31'h0000_0000, swSleep_q};
        end else if (s_axi_araddr == `CKS_ADDR_STAT) begin
            rdValue = {24'h00_0000, 1'b0, state_q, coreClockEnable, configInvalid, activeSource};
        end else if (s_axi_araddr == `CKS_ADDR_CFG) begin
            rdValue = {26'h000_0000, sutCfg_q, selCfg_q};
        end else begin
            rdOk = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wdTickPrev_q <= 1'b0;
            srcTickPrev_q <= 1'b0;
            wakePrev_q <= 1'b0;
            sleepPrev_q <= 1'b0;
            cfgCaught_q <= 1'b0;
            selCfg_q <= `CKS_SEL_DEFAULT;
            sutCfg_q <= `CKS_SUT_DEFAULT;
            state_q <= CKS_ST_RESET;
            count_q <= 17'd0;
        end else begin
            wdTickPrev_q <= wdTickLvl;
            srcTickPrev_q <= srcTickLvl;
            wakePrev_q <= wakeLvl;
            sleepPrev_q <= sleepLvl;
            cfgCaught_q <= 1'b1;
            if (!cfgCaught_q) begin
                selCfg_q <= selLive;
                sutCfg_q <= sutLive;
            end
            state_q <= state_d;
            count_q <= count_d;
        end
    end

    // Trim loads the factory byte on the first edge after reset, then software may rewrite it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trim_q <= `CKS_TRIM_NOMINAL;
            swSleep_q <= 1'b0;
        end else if (!cfgCaught_q) begin
            trim_q <= factoryTrim; // R5
            swSleep_q <= 1'b0;
        end else begin
            if (wrTrim && wrStrb[0]) begin
                trim_q <= wrData[7:0]; // R7
            end
            if (wrCtrl && wrStrb[0]) begin
                swSleep_q <= wrData[0];
            end else if (state_q == CKS_ST_SLEEP) begin
                swSleep_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 12'h000;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            badWrite_q <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CKS_RESP_OKAY;
        end else begin
            if (doWrite) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                badWrite_q <= !wrMapped;
            end else begin
                if (awTake) begin
                    awHeld_q <= 1'b1;
                    awAddr_q <= s_axi_awaddr;
                end
                if (wTake) begin
                    wHeld_q <= 1'b1;
                    wData_q <= s_axi_wdata;
                    wStrb_q <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
            if (rdTake) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdValue;
                s_axi_rresp <= rdOk ? `CKS_RESP_OKAY : `CKS_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    assign s_axi_bresp = badWrite_q ? `CKS_RESP_SLVERR : `CKS_RESP_OKAY;

    // Status outputs; configuration is static after capture so registered sources suffice
    logic coreEn_q;
    logic [1:0] src_q;
    logic [2:0] band_q;
    logic inval_q;
    logic nvmUnsafe_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            coreEn_q <= 1'b0;
            src_q <= 2'(CKS_SRC_INTRC);
            band_q <= 3'd0;
            inval_q <= 1'b0;
            nvmUnsafe_q <= 1'b0;
        end else begin
            coreEn_q <= state_d == CKS_ST_RUN; // R15
            src_q <= 2'(srcDec);
            band_q <= bandDec;
            inval_q <= cfgCaught_q && srcDec == CKS_SRC_INVALID; // R15
            // Flags trim above nominal midpoint; software must keep writes inside the 10% margin
            nvmUnsafe_q <= trim_q > `CKS_TRIM_NOMINAL; // R9
        end
    end

    assign coreClockEnable = coreEn_q;
    assign activeSource = src_q;
    assign frequencyBand = band_q;
    assign oscillatorTrimValue = trim_q;
    assign nvmTimingFromIntRc = 1'b1; // R8
    assign nvmTrimUnsafe = nvmUnsafe_q;
    assign configInvalid = inval_q;
endmodule

// ### cks_defines.svh
// Constants for the clock source select and start-up block
// How it works
// R1: Select codes 0101..1000 run the core from the external RC oscillator in four bands.
// R2: With external RC, start-up codes 00/01/10 give 18 wake cycles and no, 4.1 ms or 65 ms reset delay, 11 gives 6 cycles plus 4.1 ms.
// R3: Select codes 0001..0100 run the core from the internal RC oscillator at 1, 2, 4 or 8 MHz.
// R4: With internal RC, wake takes 6 cycles and codes 00/01/10 add no, 4.1 ms or 65 ms reset delay, 11 is reserved.
// R5: Every reset copies the factory trim byte into the trim register.
// R6: The reset time-out is timed from the watchdog oscillator whatever the core clock is.
// R7: The trim value raises the internal oscillator frequency monotonically from 0x00 lowest to 0xFF highest.
// R8: Nonvolatile memory write timing is taken from the calibrated internal oscillator.
// R9: Software writing nonvolatile memory must not trim the oscillator more than 10% above nominal.
// R10: Select code 0000 takes the core clock straight from the external clock input pin.
// R11: With external clock, wake takes 6 cycles and codes 00/01/10 add no, 4.1 ms or 65 ms reset delay, 11 is reserved.
// R12: The external clock must not change more than 2% per cycle except while the device is in reset.
// R13: Unprogrammed configuration is select 0001 with start-up 10.
// R14: The 4.1 ms delay is 4096 watchdog cycles and the 65 ms delay is 65536 watchdog cycles.
// R15: The core clock stays gated until the start-up counter finishes, and reserved codes are flagged invalid.
`ifndef CKS_DEFINES_SVH
`define CKS_DEFINES_SVH

`define CKS_ADDR_TRIM 12'h000
`define CKS_ADDR_CTRL 12'h004
`define CKS_ADDR_STAT 12'h008
`define CKS_ADDR_CFG 12'h00C

`define CKS_SEL_EXTCLK 4'h0
`define CKS_SEL_INT_LO 4'h1
`define CKS_SEL_INT_HI 4'h4
`define CKS_SEL_ERC_LO 4'h5
`define CKS_SEL_ERC_HI 4'h8
`define CKS_SEL_DEFAULT 4'h1
`define CKS_SUT_DEFAULT 2'h2

`define CKS_WAKE_ERC 5'h12
`define CKS_WAKE_SHORT 5'h06
`define CKS_WD_SHORT 17'h0_1000
`define CKS_WD_LONG 17'h1_0000

`define CKS_RESP_OKAY 2'h0
`define CKS_RESP_SLVERR 2'h2
`define CKS_TRIM_NOMINAL 8'h7F

`endif

// ### cks_pkg.sv
// Types for the clock source select and start-up block
package cks_pkg;
    typedef enum logic [1:0] {
        CKS_SRC_EXTCLK,
        CKS_SRC_INTRC,
        CKS_SRC_EXTRC,
        CKS_SRC_INVALID
    } cks_src_t;

    typedef enum logic [2:0] {
        CKS_ST_RESET,
        CKS_ST_TIMEOUT,
        CKS_ST_WAKE,
        CKS_ST_RUN,
        CKS_ST_SLEEP,
        CKS_ST_HALT
    } cks_state_t;
endpackage

// ### cks_sync.sv
// Two-flop synchroniser for pin and foreign-clock inputs
`timescale 1ns/10ps
module cks_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            synced <= '0;
        end else begin
            meta_q <= async;
            synced <= meta_q;
        end
    end
endmodule

// ### cks_clock_ctrl_asserts.sv
// Port-level assertion checker for the clock control block
`timescale 1ns/10ps
module cks_clock_ctrl_asserts (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] clockSourceSelect,
    input wire logic configProgrammed,
    input wire logic [7:0] factoryTrim,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic coreClockEnable,
    input wire logic [1:0] activeSource,
    input wire logic [2:0] frequencyBand,
    input wire logic [7:0] oscillatorTrimValue,
    input wire logic nvmTimingFromIntRc,
    input wire logic nvmTrimUnsafe,
    input wire logic configInvalid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    trim_load_a: assert property ($rose(resetn) |=> oscillatorTrimValue == $past(factoryTrim))
        else $error("trim not loaded from factory byte");
    nvm_clock_a: assert property (nvmTimingFromIntRc) else $error("nvm timing source lost");
    trim_limit_a: assert property ($stable(oscillatorTrimValue) |->
        nvmTrimUnsafe == (oscillatorTrimValue > 8'h7F)) else $error("unsafe trim flag wrong");
    bad_cfg_gate_a: assert property (configInvalid |-> !coreClockEnable)
        else $error("clock enabled with invalid config");
    int_decode_a: assert property (coreClockEnable && configProgrammed &&
        clockSourceSelect inside {[4'h1:4'h4]} |-> activeSource == 2'd1 &&
        frequencyBand == clockSourceSelect - 4'h1) else $error("internal rc decode wrong");
    rc_decode_a: assert property (coreClockEnable && configProgrammed &&
        clockSourceSelect inside {[4'h5:4'h8]} |-> activeSource == 2'd2 &&
        frequencyBand == clockSourceSelect - 4'h5) else $error("external rc decode wrong");
    ext_decode_a: assert property (coreClockEnable && configProgrammed &&
        clockSourceSelect == 4'h0 |-> activeSource == 2'd0) else $error("ext clock decode wrong");
    default_cfg_a: assert property (coreClockEnable && !configProgrammed |->
        activeSource == 2'd1 && frequencyBand == 3'd0) else $error("default config wrong");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid) else $error("write response late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule
bind cks_clock_ctrl cks_clock_ctrl_asserts chkInst (.*);

// ### cks_osc_model.sv
// Stand-ins for the selected source oscillator and the watchdog oscillator
`timescale 1ns/10ps
module cks_osc_model #(
    parameter int WD_HALF = 20,
    parameter int SRC_HALF = 8
) (
    output logic watchdogOscTick,
    output logic sourceClockTick
);
    // Fixed rates, so the source never steps more than allowed between cycles
    initial begin
        watchdogOscTick = 1'b0;
        sourceClockTick = 1'b0;
    end
    always #(WD_HALF) watchdogOscTick = ~watchdogOscTick;
    always #(SRC_HALF) sourceClockTick = ~sourceClockTick;
endmodule

// ### tb.sv
// Self-checking bench for the clock control block
`timescale 1ns/10ps
`include "cks_defines.svh"
module tb;
    localparam int WDP = 10;
    localparam int SRCP = 4;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] clockSourceSelect = 4'h1;
    logic [1:0] startupDelaySelect = 2'h2;
    logic configProgrammed = 1'b0, wakeRequest = 1'b0, sleepRequest = 1'b0;
    logic [7:0] factoryTrim = 8'h5A;
    logic watchdogOscTick, sourceClockTick;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, activeSource;
    logic [31:0] s_axi_rdata;
    logic [2:0] frequencyBand;
    logic [7:0] oscillatorTrimValue;
    logic coreClockEnable, nvmTimingFromIntRc, nvmTrimUnsafe, configInvalid;
    int errorCnt = 0, checkCount = 0;
    always #2 clk = ~clk;
    // Short watchdog counts keep the long reset delay to about 160 clock cycles
    cks_clock_ctrl #(.WD_SHORT_CYCLES(8), .WD_LONG_CYCLES(16)) dut (.*);
    cks_osc_model osc (.watchdogOscTick(watchdogOscTick), .sourceClockTick(sourceClockTick));
    task automatic endOfTest();
        $display("checks %0d mismatches %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checkCount++;
        if (g !== e) begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic waitEn(input logic lvl, input int lim, output int n);
        n = 0;
        while (coreClockEnable !== lvl && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("coreClockEnable", lvl, coreClockEnable);
        if (coreClockEnable !== lvl) endOfTest();
    endtask
    task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
                            input logic [1:0] er);
        int n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        chk("bvalid", 1, s_axi_bvalid);
        if (s_axi_bvalid !== 1'b1) endOfTest();
        chk("bresp", er, s_axi_bresp);
    endtask
    task automatic axiRead(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        chk("rvalid", 1, s_axi_rvalid);
        if (s_axi_rvalid !== 1'b1) endOfTest();
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask
    task automatic startCfg(input logic p, input logic [3:0] s, input logic [1:0] u, input int wd,
                            input int wk, input logic [1:0] es, input logic [2:0] eb);
        int n;
        int e;
        @(posedge clk);
        resetn <= 1'b0;
        configProgrammed <= p;
        clockSourceSelect <= s;
        startupDelaySelect <= u;
        factoryTrim <= 8'h30 + 8'(s);
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        #1;
        if (es == 2'd3) begin
            // Reserved codes must never let the core clock through
            repeat (300) @(posedge clk);
            chk("configInvalid", 1, configInvalid);
            chk("coreClockEnable", 0, coreClockEnable);
        end else begin
            e = wd * WDP + wk * SRCP;
            waitEn(1'b1, 400, n);
            chk("startup cycles", 1, n >= e - WDP - SRCP && n <= e + 20);
            chk("frequencyBand", eb, frequencyBand);
        end
        chk("activeSource", es, activeSource);
        axiRead(`CKS_ADDR_TRIM, {24'h0, 8'h30 + 8'(s)}, `CKS_RESP_OKAY);
        $display("config %h/%h done", s, u);
    endtask
    task automatic regTest();
        axiWrite(`CKS_ADDR_TRIM, 32'h0000_0080, 4'hF, `CKS_RESP_OKAY);
        axiWrite(`CKS_ADDR_TRIM, 32'h0000_00FF, 4'h0, `CKS_RESP_OKAY);
        axiRead(`CKS_ADDR_TRIM, 32'h0000_0080, `CKS_RESP_OKAY);
        chk("oscillatorTrimValue", 8'h80, oscillatorTrimValue);
        chk("nvmTrimUnsafe", 1, nvmTrimUnsafe);
        // Software side keeps the trim at or below nominal before nvm writes
        axiWrite(`CKS_ADDR_TRIM, 32'h0000_0070, 4'hF, `CKS_RESP_OKAY);
        axiRead(`CKS_ADDR_TRIM, 32'h0000_0070, `CKS_RESP_OKAY);
        chk("nvmTrimUnsafe", 0, nvmTrimUnsafe);
        chk("nvmTimingFromIntRc", 1, nvmTimingFromIntRc);
        // Last start-up left ext RC band 0, no delay code, sequencer running
        axiRead(`CKS_ADDR_CFG, 32'h0000_0005, `CKS_RESP_OKAY);
        axiRead(`CKS_ADDR_STAT, 32'h0000_003A, `CKS_RESP_OKAY);
        axiWrite(12'h010, 32'h0000_0001, 4'hF, `CKS_RESP_SLVERR);
        axiRead(12'h010, 32'h0000_0000, `CKS_RESP_SLVERR);
        $display("register test done");
    endtask
    task automatic sleepTest();
        int n;
        @(posedge clk);
        sleepRequest <= 1'b1;
        waitEn(1'b0, 20, n);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            sleepRequest <= 1'b0;
            wakeRequest <= 1'b1;
            waitEn(1'b1, 200, n);
            // Wake from sleep adds no reset delay, only the source cycles
            chk("wake cycles", 1, n >= 17 * SRCP - 2 && n <= 18 * SRCP + 12);
            @(posedge clk);
            wakeRequest <= 1'b0;
            axiWrite(`CKS_ADDR_CTRL, 32'h0000_0001, 4'hF, `CKS_RESP_OKAY);
            waitEn(1'b0, 20, n);
        end
        // Software sleep request clears itself once sleep is entered
        axiRead(`CKS_ADDR_CTRL, 32'h0000_0000, `CKS_RESP_OKAY);
        $display("sleep test done");
    endtask
    initial begin
        startCfg(1, 4'h0, 2'h0, 0, 6, 2'd0, 3'd0);
        startCfg(1, 4'h0, 2'h2, 16, 6, 2'd0, 3'd0);
        startCfg(1, 4'h1, 2'h1, 8, 6, 2'd1, 3'd0);
        startCfg(1, 4'h2, 2'h0, 0, 6, 2'd1, 3'd1);
        startCfg(1, 4'h3, 2'h2, 16, 6, 2'd1, 3'd2);
        startCfg(1, 4'h4, 2'h0, 0, 6, 2'd1, 3'd3);
        startCfg(1, 4'h6, 2'h1, 8, 18, 2'd2, 3'd1);
        startCfg(1, 4'h7, 2'h2, 16, 18, 2'd2, 3'd2);
        startCfg(1, 4'h8, 2'h3, 8, 6, 2'd2, 3'd3);
        startCfg(0, 4'hF, 2'h3, 16, 6, 2'd1, 3'd0);
        startCfg(1, 4'h0, 2'h3, 0, 0, 2'd3, 3'd0);
        startCfg(1, 4'h1, 2'h3, 0, 0, 2'd3, 3'd0);
        startCfg(1, 4'h9, 2'h0, 0, 0, 2'd3, 3'd0);
        startCfg(1, 4'h5, 2'h0, 0, 18, 2'd2, 3'd0);
        regTest();
        sleepTest();
        endOfTest();
    end
endmodule
